// ### src/prps_defs.svh
`ifndef PRPS_DEFS_SVH
`define PRPS_DEFS_SVH

// clock rate and timing figures
`define PRPS_CLK_MHZ 100
`define PRPS_RST_HOLD_MS 50
`define PRPS_FLT_RST_US 100
`define PRPS_STAG_STEP_US 500
`define PRPS_CNT_W 23

// register indices; byte address is four times the index
`define PRPS_IDX_SEQ_CTRL 8'h80
`define PRPS_IDX_BATT_CTRL 8'h89
`define PRPS_IDX_STATUS 8'h90
`define PRPS_IDX_THERM 8'h91
`define PRPS_ADR_W 10

// sequencer control fields
`define PRPS_HV_SW_BIT 0
`define PRPS_LV_SW_BIT 1
`define PRPS_BYPASS_BIT 2
`define PRPS_DLY_LO 4
`define PRPS_DLY_HI 5
`define PRPS_DLY_RST 2'h2

// battery control fields
`define PRPS_NO_BACKUP_BATTERY_BIT 7

// thermal register fields
`define PRPS_ENALL_BIT 7
`define PRPS_CODE_HI 2

// status fields
`define PRPS_ST_OK_HI 2
`define PRPS_ST_RSTO_BIT 4
`define PRPS_ST_FLT_BIT 5
`define PRPS_ST_MAIN_BIT 6
`define PRPS_ST_WARN_BIT 7

// thermal comparator use
`define PRPS_N_CMP 6
`define PRPS_CMP_ALWAYS 6'h03
`define PRPS_CMP_ALL 6'h3F
`endif

// ### src/prps_pkg.sv
`default_nettype none
package prps_pkg;
  // reset output sequencing
  typedef enum logic [1:0] {
    RS_WAIT = 2'b00,
    RS_HOLD = 2'b01,
    RS_RUN = 2'b10,
    RS_FLTDLY = 2'b11
  } prps_rst_state_t;

  // high-voltage group sequencing
  typedef enum logic [1:0] {
    HV_OFF = 2'b00,
    HV_UP = 2'b01,
    HV_ON = 2'b10,
    HV_DOWN = 2'b11
  } prps_hv_state_t;

  // classic wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } prps_wb_req_t;

  // wishbone answer to the master
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } prps_wb_rsp_t;
endpackage
`default_nettype wire

// ### src/prps_sequencer.sv
// Local design decisions: the Wishbone register port and the placing of the registers.
`include "prps_defs.svh"
`default_nettype none

module prps_sequencer #(
  parameter int unsigned RST_HOLD_CYC = `PRPS_RST_HOLD_MS * 1000 * `PRPS_CLK_MHZ,
  parameter int unsigned FLT_RST_CYC = `PRPS_FLT_RST_US * `PRPS_CLK_MHZ,
  parameter int unsigned STAG_STEP_CYC = `PRPS_STAG_STEP_US * `PRPS_CLK_MHZ
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register bus
  input wire prps_pkg::prps_wb_req_t wb_req,
  output prps_pkg::prps_wb_rsp_t wb_rsp,
  // supplies and hardware reset
  input wire logic reset_in_n,
  input wire logic backup_present,
  input wire logic main_present,
  input wire logic rtc_stable,
  // battery comparators
  input wire logic bat_above_hi,
  input wire logic bat_above_lo,
  // processor enables
  input wire logic high_voltage_power_enable,
  input wire logic low_voltage_power_enable,
  // regulator feedback and thermal comparators
  input wire logic [2:0] reg_good,
  input wire logic [5:0] therm_cmp,
  // pin outputs
  output logic reset_out_n,
  output logic battery_fault_n,
  output logic first_regulator_en,
  output logic hv_others_en,
  output logic lv_regs_en,
  output logic rtc_on_main,
  output logic thermal_warning,
  output logic [5:0] therm_cmp_en
);

  // number of cycles for a stagger code
  function automatic logic [`PRPS_CNT_W-1:0] stag_cycles(input logic [1:0] sel);
    logic [31:0] c;
    c = STAG_STEP_CYC * 32'(sel);
    stag_cycles = c[`PRPS_CNT_W-1:0];
  endfunction

  // number of set comparators as a binary code
  function automatic logic [2:0] therm_code(input logic [5:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < `PRPS_N_CMP; i++) begin
      n = n + {2'h0, v[i]};
    end
    therm_code = n;
  endfunction
  localparam logic [`PRPS_CNT_W-1:0] HOLD_LAST = `PRPS_CNT_W'(RST_HOLD_CYC - 1);
  localparam logic [`PRPS_CNT_W-1:0] FLT_LAST = `PRPS_CNT_W'(FLT_RST_CYC - 1);
  prps_pkg::prps_rst_state_t rst_state_reg;
  prps_pkg::prps_hv_state_t hv_state_reg;
  logic [`PRPS_CNT_W-1:0] rst_cnt_reg;
  logic [`PRPS_CNT_W-1:0] stag_cnt_reg;
  logic fault_seen_reg;
  logic [7:0] seq_ctrl_reg;
  logic no_backup_battery_reg;
  logic enall_reg;
  logic [1:0] hi_sync_reg;
  logic [1:0] lo_sync_reg;
  logic [2:0] code_reg;
  logic hv_req;
  logic lv_req;
  logic wb_hit;
  logic wb_wr;
  logic [7:0] wb_idx;

  // bus decode
  assign wb_hit = wb_req.cyc & wb_req.stb & ~wb_rsp.ack;
  assign wb_wr = wb_hit & wb_req.we & wb_req.sel[0];
  assign wb_idx = wb_req.adr[`PRPS_ADR_W-1:2];
  // enables from pins or register bits
  assign hv_req = high_voltage_power_enable | seq_ctrl_reg[`PRPS_HV_SW_BIT];
  assign lv_req = low_voltage_power_enable | seq_ctrl_reg[`PRPS_LV_SW_BIT];
  // control register writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seq_ctrl_reg <= {2'h0, `PRPS_DLY_RST, 4'h0};
      no_backup_battery_reg <= 1'b0;
      enall_reg <= 1'b0;
    end else if (wb_wr) begin
      case (wb_idx)
        `PRPS_IDX_SEQ_CTRL: seq_ctrl_reg <= wb_req.dat[7:0];
        `PRPS_IDX_BATT_CTRL: no_backup_battery_reg <= wb_req.dat[`PRPS_NO_BACKUP_BATTERY_BIT];
        `PRPS_IDX_THERM: enall_reg <= wb_req.dat[`PRPS_ENALL_BIT];
        default: ;
      endcase
    end
  end

  // bus answer: ack one cycle after the request, dropped the next cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wb_rsp <= '0;
    end else begin
      wb_rsp.ack <= wb_hit;
      wb_rsp.dat <= 32'h0;
      if (wb_hit && !wb_req.we) begin
        case (wb_idx)
          `PRPS_IDX_SEQ_CTRL: wb_rsp.dat <= {24'h0, seq_ctrl_reg};
          `PRPS_IDX_BATT_CTRL: wb_rsp.dat <= {24'h0, no_backup_battery_reg, 7'h0};
          `PRPS_IDX_STATUS: wb_rsp.dat <= {24'h0, thermal_warning, rtc_on_main,
            battery_fault_n, reset_out_n, 1'b0,
            reg_good & {lv_regs_en, hv_others_en, first_regulator_en}};
          `PRPS_IDX_THERM: wb_rsp.dat <= {24'h0, enall_reg, 4'h0, code_reg};
          default: wb_rsp.dat <= 32'h0;
        endcase
      end
    end
  end

  // battery fault output follows main supply
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      battery_fault_n <= 1'b0;
    end else begin
      battery_fault_n <= main_present;
    end
  end

  // remembers a supply loss after the processor was released
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fault_seen_reg <= 1'b0;
    end else if (rst_state_reg == prps_pkg::RS_RUN && !battery_fault_n) begin
      fault_seen_reg <= 1'b1;
    end else if (rst_state_reg != prps_pkg::RS_RUN) begin
      fault_seen_reg <= 1'b0;
    end
  end

  // reset output sequencing
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rst_state_reg <= prps_pkg::RS_WAIT;
      rst_cnt_reg <= '0;
      reset_out_n <= 1'b0;
    end else if (!reset_in_n) begin
      rst_state_reg <= prps_pkg::RS_HOLD;
      rst_cnt_reg <= '0;
      reset_out_n <= 1'b0;
    end else begin
      case (rst_state_reg)
        prps_pkg::RS_WAIT: begin
          reset_out_n <= 1'b0;
          rst_cnt_reg <= '0;
          if (rtc_stable && (backup_present || main_present)) begin
            rst_state_reg <= prps_pkg::RS_HOLD;
          end
        end
        prps_pkg::RS_HOLD: begin
          reset_out_n <= 1'b0;
          if (rst_cnt_reg == HOLD_LAST) begin
            rst_state_reg <= prps_pkg::RS_RUN;
            reset_out_n <= 1'b1;
          end else begin
            rst_cnt_reg <= rst_cnt_reg + `PRPS_CNT_W'(1);
          end
        end
        prps_pkg::RS_RUN: begin
          rst_cnt_reg <= '0;
          if (fault_seen_reg && battery_fault_n) begin
            rst_state_reg <= prps_pkg::RS_FLTDLY;
          end
        end
        prps_pkg::RS_FLTDLY: begin
          if (rst_cnt_reg == FLT_LAST) begin
            rst_state_reg <= prps_pkg::RS_HOLD;
            rst_cnt_reg <= '0;
            reset_out_n <= 1'b0;
          end else begin
            rst_cnt_reg <= rst_cnt_reg + `PRPS_CNT_W'(1);
          end
        end
        default: begin
          rst_state_reg <= prps_pkg::RS_WAIT;
          reset_out_n <= 1'b0;
        end
      endcase
    end
  end

  // high-voltage group: first regulator up first, down last
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hv_state_reg <= prps_pkg::HV_OFF;
      stag_cnt_reg <= '0;
      first_regulator_en <= 1'b0;
      hv_others_en <= 1'b0;
    end else if (!reset_in_n) begin
      stag_cnt_reg <= '0;
    end else begin
      case (hv_state_reg)
        prps_pkg::HV_OFF: begin
          stag_cnt_reg <= '0;
          if (hv_req) begin
            first_regulator_en <= 1'b1;
            hv_state_reg <= prps_pkg::HV_UP;
          end
        end
        prps_pkg::HV_UP: begin
          if (!hv_req) begin
            stag_cnt_reg <= '0;
            hv_state_reg <= prps_pkg::HV_DOWN;
          end else if (stag_cnt_reg >= stag_cycles(seq_ctrl_reg[`PRPS_DLY_HI:`PRPS_DLY_LO])) begin
            hv_others_en <= 1'b1;
            hv_state_reg <= prps_pkg::HV_ON;
          end else begin
            stag_cnt_reg <= stag_cnt_reg + `PRPS_CNT_W'(1);
          end
        end
        prps_pkg::HV_ON: begin
          stag_cnt_reg <= '0;
          if (!hv_req) begin
            hv_others_en <= 1'b0;
            hv_state_reg <= prps_pkg::HV_DOWN;
          end
        end
        prps_pkg::HV_DOWN: begin
          hv_others_en <= 1'b0;
          if (stag_cnt_reg >= stag_cycles(seq_ctrl_reg[`PRPS_DLY_HI:`PRPS_DLY_LO])) begin
            first_regulator_en <= 1'b0;
            hv_state_reg <= prps_pkg::HV_OFF;
          end else begin
            stag_cnt_reg <= stag_cnt_reg + `PRPS_CNT_W'(1);
          end
        end
        default: begin
          hv_state_reg <= prps_pkg::HV_OFF;
          first_regulator_en <= 1'b0;
          hv_others_en <= 1'b0;
        end
      endcase
    end
  end

  // low-voltage group, gated by the high-voltage enable unless bypassed
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lv_regs_en <= 1'b0;
    end else begin
      lv_regs_en <= lv_req & (hv_req | seq_ctrl_reg[`PRPS_BYPASS_BIT]);
    end
  end

  // battery comparator synchronisers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hi_sync_reg <= 2'h0;
      lo_sync_reg <= 2'h0;
    end else begin
      hi_sync_reg <= {hi_sync_reg[0], bat_above_hi};
      lo_sync_reg <= {lo_sync_reg[0], bat_above_lo};
    end
  end

  // battery switch selection with hysteresis
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rtc_on_main <= 1'b0;
    end else if (no_backup_battery_reg) begin
      rtc_on_main <= 1'b1;
    end else if (!backup_present) begin
      rtc_on_main <= 1'b1;
    end else if (!main_present) begin
      rtc_on_main <= 1'b0;
    end else if (rtc_on_main && !lo_sync_reg[1]) begin
      rtc_on_main <= 1'b0;
    end else if (!rtc_on_main && hi_sync_reg[1]) begin
      rtc_on_main <= 1'b1;
    end
  end

  // thermal warning with hysteresis, comparator enables and coded flags
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      thermal_warning <= 1'b0;
      therm_cmp_en <= `PRPS_CMP_ALWAYS;
      code_reg <= 3'h0;
    end else begin
      if (therm_cmp[0]) begin
        thermal_warning <= 1'b1;
      end else if (!therm_cmp[1]) begin
        thermal_warning <= 1'b0;
      end
      therm_cmp_en <= enall_reg ? `PRPS_CMP_ALL : `PRPS_CMP_ALWAYS;
      code_reg <= therm_code(therm_cmp & therm_cmp_en);
    end
  end
  // helper: cycles the reset output has been low
  logic [`PRPS_CNT_W-1:0] low_cnt_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_cnt_reg <= '0;
    end else if (reset_out_n) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != '1) begin
      low_cnt_reg <= low_cnt_reg + `PRPS_CNT_W'(1);
    end
  end
  // checks
  chk_hold_min_low: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(reset_out_n) |-> low_cnt_reg >= HOLD_LAST)
    else $error("reset output released too early");
  chk_cold_wait_low: assert property (@(posedge ref_clk) disable iff (rst)
    rst_state_reg == prps_pkg::RS_WAIT |=> !reset_out_n)
    else $error("reset output released before supplies stable");
  chk_hw_reset_low: assert property (@(posedge ref_clk) disable iff (rst)
    !reset_in_n |=> !reset_out_n && rst_cnt_reg == '0)
    else $error("hardware reset did not pull reset output");
  chk_fault_release: assert property (@(posedge ref_clk) disable iff (rst)
    main_present |=> battery_fault_n)
    else $error("battery fault not released with main supply");
  chk_first_leads: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(hv_others_en) |-> first_regulator_en && $past(first_regulator_en))
    else $error("other supplies came up before the first regulator");
  chk_first_trails: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(first_regulator_en) |-> !hv_others_en && !$past(hv_others_en))
    else $error("first regulator went off before the others");
  chk_lv_gating: assert property (@(posedge ref_clk) disable iff (rst)
    lv_regs_en |-> $past(lv_req) && ($past(hv_req) || $past(seq_ctrl_reg[`PRPS_BYPASS_BIT])))
    else $error("low-voltage group on without its enable or gating");
  chk_no_backup_battery_main: assert property (@(posedge ref_clk) disable iff (rst)
    no_backup_battery_reg |=> rtc_on_main)
    else $error("switch left main with no-backup bit set");
  chk_warn_set: assert property (@(posedge ref_clk) disable iff (rst)
    therm_cmp[0] |=> thermal_warning)
    else $error("thermal warning not raised");
  chk_bus_ack: assert property (@(posedge ref_clk) disable iff (rst)
    wb_hit |=> wb_rsp.ack ##1 !wb_rsp.ack)
    else $error("bus answer not a single cycle");

endmodule
`default_nettype wire

// ### tb/prps_cpu_model.sv
`default_nettype none
module prps_cpu_model #(
  parameter int T_SYS = 10,
  parameter int T_PWR = 30
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bench control and device outputs
  input wire logic start,
  input wire logic reset_out_n,
  input wire logic battery_fault_n,
  // enables toward the device
  output logic hv_en,
  output logic lv_en
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_reg;
  // boot countdowns, enables raised in order and dropped when told to stop
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 0;
      hv_en <= 1'h0;
      lv_en <= 1'h0;
    end else if (!start) begin
      cnt_reg <= 0;
      hv_en <= 1'h0;
      lv_en <= 1'h0;
    end else if (!hv_en) begin
      if (reset_out_n && battery_fault_n) begin // both releases, any order
        cnt_reg <= cnt_reg + 1;
        if (cnt_reg == T_SYS) begin // pause after reset release
          hv_en <= 1'h1;
          cnt_reg <= 0;
        end
      end else begin
        cnt_reg <= 0;
      end
    end else if (!lv_en) begin
      cnt_reg <= cnt_reg + 1;
      if (cnt_reg == T_PWR) begin // countdown before low-voltage enable
        lv_en <= 1'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/test_prps_sequencer.sv
`include "prps_defs.svh"
`default_nettype none
module test_prps_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20;
  localparam int FLT = 5;
  localparam int STEP = 4;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  prps_pkg::prps_wb_req_t wb_req = '0;
  prps_pkg::prps_wb_rsp_t wb_rsp;
  logic reset_in_n = 1'h1, backup_present = 1'h0, main_present = 1'h0, rtc_stable = 1'h0;
  logic bat_above_hi = 1'h0, bat_above_lo = 1'h0, cpu_start = 1'h0, hv_pin, lv_pin;
  logic [2:0] reg_good = 3'h0;
  logic [5:0] therm_cmp = 6'h00, therm_cmp_en;
  logic reset_out_n, battery_fault_n, first_regulator_en, hv_others_en, lv_regs_en, rtc_on_main, thermal_warning;
  logic [1:0] prev_hv = 2'h0;
  logic [31:0] rd_val;
  logic [2:0] bat_tbl [5] = '{3'h7, 3'h3, 3'h0, 3'h2, 3'h7};
  int n_mismatch = 0, tests_run = 0, cyc = 0, t_fu = 0, t_ou = 0, t_od = 0, t_fd = 0, n;

  // free-running clock
  always #5 ref_clk = ~ref_clk;

  prps_sequencer #(.RST_HOLD_CYC(HOLD), .FLT_RST_CYC(FLT), .STAG_STEP_CYC(STEP)) u_prps_sequencer (
    .ref_clk(ref_clk), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp), .reset_in_n(reset_in_n),
    .backup_present(backup_present), .main_present(main_present), .rtc_stable(rtc_stable),
    .bat_above_hi(bat_above_hi), .bat_above_lo(bat_above_lo), .high_voltage_power_enable(hv_pin),
    .low_voltage_power_enable(lv_pin), .reg_good(reg_good), .therm_cmp(therm_cmp), .reset_out_n(reset_out_n),
    .battery_fault_n(battery_fault_n), .first_regulator_en(first_regulator_en), .hv_others_en(hv_others_en),
    .lv_regs_en(lv_regs_en), .rtc_on_main(rtc_on_main), .thermal_warning(thermal_warning),
    .therm_cmp_en(therm_cmp_en));

  prps_cpu_model u_prps_cpu_model (.ref_clk(ref_clk), .rst(rst), .start(cpu_start), .reset_out_n(reset_out_n),
    .battery_fault_n(battery_fault_n), .hv_en(hv_pin), .lv_en(lv_pin));

  // edge times of the high-voltage group enables
  always @(negedge ref_clk) begin
    cyc <= cyc + 1;
    prev_hv <= {first_regulator_en, hv_others_en};
    if (first_regulator_en && !prev_hv[1]) t_fu <= cyc;
    if (!first_regulator_en && prev_hv[1]) t_fd <= cyc;
    if (hv_others_en && !prev_hv[0]) t_ou <= cyc;
    if (!hv_others_en && prev_hv[0]) t_od <= cyc;
  end

  task automatic print_verdict();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic fail_wait();
    n_mismatch++;
    $display("unexpected at %0t: wait ran out", $time);
    print_verdict();
  endtask

  // counts falling edges until the signal shows the level
  task automatic wait_lvl(ref logic s, input logic lvl, output int k);
    k = 0;
    while (s !== lvl && k < 300) begin
      @(negedge ref_clk);
      k++;
    end
    if (k >= 300) fail_wait();
  endtask

  // one classic single cycle, held until the rising edge that samples ack high
  task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge ref_clk);
    wb_req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: {idx, 2'h0}, sel: 4'hF, dat: wd};
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_rsp.ack !== 1'h1 && k < 50);
    if (k >= 50) fail_wait();
    rd = wb_rsp.dat;
    wb_req <= '0;
  endtask

  task automatic wb_wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    wb_xfer(1'h1, idx, wd, d);
  endtask

  task automatic wb_rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    wb_xfer(1'h0, idx, 32'h0, d);
    check(d, exp);
  endtask

  task automatic t_reset_values();
    check(32'(reset_out_n), 32'h0);
    check(32'(therm_cmp_en), 32'h03);
    wb_rd(`PRPS_IDX_SEQ_CTRL, 32'h20);
    wb_rd(`PRPS_IDX_BATT_CTRL, 32'h0);
    wb_wr(8'h10, 32'hFF);
    wb_rd(8'h10, 32'h0);
  endtask

  task automatic t_cold_start();
    @(posedge ref_clk);
    backup_present <= 1'h1;
    main_present <= 1'h1;
    repeat (30) @(negedge ref_clk);
    check(32'(reset_out_n), 32'h0);
    check(32'(battery_fault_n), 32'h1);
    @(posedge ref_clk);
    rtc_stable <= 1'h1;
    wait_lvl(reset_out_n, 1'h1, n);
    check(32'(n >= HOLD && n <= HOLD + 3), 32'h1);
  endtask

  task automatic t_hw_reset();
    @(posedge ref_clk);
    reset_in_n <= 1'h0;
    repeat (3) @(negedge ref_clk);
    check(32'(reset_out_n), 32'h0);
    @(posedge ref_clk);
    reset_in_n <= 1'h1;
    repeat (10) @(posedge ref_clk);
    reset_in_n <= 1'h0;
    @(posedge ref_clk);
    reset_in_n <= 1'h1;
    wait_lvl(reset_out_n, 1'h1, n);
    check(32'(n >= HOLD && n <= HOLD + 3), 32'h1);
  endtask

  task automatic t_stagger();
    for (int d = 0; d < 4; d++) begin
      wb_wr(`PRPS_IDX_SEQ_CTRL, 32'((d << 4) | 1));
      repeat (30) @(negedge ref_clk);
      check(32'(t_ou - t_fu), 32'(d * STEP + 1));
      wb_wr(`PRPS_IDX_SEQ_CTRL, 32'(d << 4));
      repeat (30) @(negedge ref_clk);
      check(32'(t_fd - t_od), 32'(d * STEP + 1));
    end
  endtask

  task automatic t_lv_gating();
    wb_wr(`PRPS_IDX_SEQ_CTRL, 32'h22);
    repeat (5) @(negedge ref_clk);
    check(32'(lv_regs_en), 32'h0);
    wb_wr(`PRPS_IDX_SEQ_CTRL, 32'h26);
    repeat (3) @(negedge ref_clk);
    check(32'(lv_regs_en), 32'h1);
    wb_wr(`PRPS_IDX_SEQ_CTRL, 32'h20);
    repeat (3) @(negedge ref_clk);
    check(32'(lv_regs_en), 32'h0);
  endtask

  task automatic t_power_up();
    @(posedge ref_clk);
    reg_good <= 3'h7;
    cpu_start <= 1'h1;
    wait_lvl(lv_regs_en, 1'h1, n);
    check(32'({first_regulator_en, hv_others_en}), 32'h3);
    repeat (30) @(negedge ref_clk); // let the regulators settle before reading OK bits
    wb_xfer(1'h0, `PRPS_IDX_STATUS, 32'h0, rd_val);
    check(rd_val & 32'h37, 32'h37);
    @(posedge ref_clk);
    reg_good <= 3'h1;
    wb_xfer(1'h0, `PRPS_IDX_STATUS, 32'h0, rd_val);
    check(rd_val & 32'h07, 32'h01);
  endtask

  task automatic t_fault_rereset();
    @(posedge ref_clk);
    main_present <= 1'h0;
    repeat (3) @(negedge ref_clk);
    check(32'(battery_fault_n), 32'h0);
    @(posedge ref_clk);
    main_present <= 1'h1;
    wait_lvl(battery_fault_n, 1'h1, n);
    wait_lvl(reset_out_n, 1'h0, n);
    check(32'(n), 32'(FLT + 1));
    wait_lvl(reset_out_n, 1'h1, n);
    check(32'(n >= HOLD && n <= HOLD + 3), 32'h1);
  endtask

  task automatic t_thermal();
    @(posedge ref_clk);
    therm_cmp <= 6'h01;
    repeat (3) @(negedge ref_clk);
    check(32'(thermal_warning), 32'h1);
    @(posedge ref_clk);
    therm_cmp <= 6'h02;
    repeat (3) @(negedge ref_clk);
    check(32'(thermal_warning), 32'h1);
    @(posedge ref_clk);
    therm_cmp <= 6'h3F;
    wb_wr(`PRPS_IDX_THERM, 32'h80);
    repeat (3) @(negedge ref_clk);
    check(32'(therm_cmp_en), 32'h3F);
    wb_rd(`PRPS_IDX_THERM, 32'h86);
    wb_wr(`PRPS_IDX_THERM, 32'h00);
    repeat (3) @(negedge ref_clk);
    wb_rd(`PRPS_IDX_THERM, 32'h02);
    therm_cmp <= 6'h00;
    repeat (3) @(negedge ref_clk);
    check(32'(thermal_warning), 32'h0);
  endtask

  task automatic t_battery();
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      {bat_above_hi, bat_above_lo} <= bat_tbl[i][2:1];
      repeat (5) @(negedge ref_clk);
      check(32'(rtc_on_main), 32'(bat_tbl[i][0]));
    end
    wb_wr(`PRPS_IDX_BATT_CTRL, 32'h80);
    {bat_above_hi, bat_above_lo} <= 2'h0;
    repeat (5) @(negedge ref_clk);
    check(32'(rtc_on_main), 32'h1);
    wb_wr(`PRPS_IDX_BATT_CTRL, 32'h00);
    backup_present <= 1'h0;
    repeat (5) @(negedge ref_clk);
    check(32'(rtc_on_main), 32'h1);
    @(posedge ref_clk);
    backup_present <= 1'h1;
    main_present <= 1'h0;
    repeat (5) @(negedge ref_clk);
    check(32'(rtc_on_main), 32'h0);
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'h0;
    t_reset_values();
    t_cold_start();
    t_hw_reset();
    t_stagger();
    t_lv_gating();
    t_power_up();
    t_fault_rereset();
    t_thermal();
    t_battery();
    print_verdict();
  end
endmodule
`default_nettype wire
